// ==== rtl/scb_params.svh ====
// scb_params.svh: constants of the system control coprocessor
// assumes inclusion by the package and the design, definitions only
`ifndef SCB_PARAMS_SVH
`define SCB_PARAMS_SVH
// register numbers, byte address is four times the number
`define SCB_IDX_IBASE 5'h00
`define SCB_IDX_INSTR_SPACE_LIMIT 5'h01
`define SCB_IDX_DATA_SPACE_BASE 5'h02
`define SCB_IDX_DATA_SPACE_LIMIT 5'h03
`define SCB_IDX_BADVA 5'h08
`define SCB_IDX_COUNT 5'h09
`define SCB_IDX_CMP 5'h0B
`define SCB_IDX_STATUS 5'h0C
`define SCB_IDX_CAUSE 5'h0D
`define SCB_IDX_EPC 5'h0E
`define SCB_IDX_PROCESSOR_IDENTITY 5'h0F
`define SCB_IDX_CONFIG 5'h10
`define SCB_IDX_REGION_CACHE_POLICY 5'h11
`define SCB_IDX_FETCH_BREAKPOINT_ADDR 5'h12
`define SCB_IDX_DATA_BREAKPOINT_ADDR 5'h13
`define SCB_IDX_ECC 5'h1A
`define SCB_IDX_CERR 5'h1B
`define SCB_IDX_TAG 5'h1C
`define SCB_IDX_EEPC 5'h1E
// status bits
`define SCB_ST_IE 0
`define SCB_ST_EXL 1
`define SCB_ST_ERL 2
`define SCB_ST_UM 4
`define SCB_ST_IVEC 23
`define SCB_ST_CU0 28
`define SCB_ST_CU1 29
// cause fields
`define SCB_CA_TIP 15
`define SCB_CODE_ADEL 5'h04
`define SCB_CODE_ADES 5'h05
`define SCB_CODE_WATCH 5'h17
// watch enables
`define SCB_WI_EN 0
`define SCB_WD_ST 0
`define SCB_WD_LD 1
// segments
`define SCB_KSEG_BASE 32'h80000000
`define SCB_UNCACHED_KERNEL_WINDOW_BASE 32'hA0000000
`define SCB_UPPER_KERNEL_SEGMENT_BASE 32'hC0000000
`define SCB_WIN_MASK 32'h1FFFFFFF
`define SCB_ATTR_UNCACHED 4'h2
// arbitrary neutral identity value
`define SCB_PROCESSOR_IDENTITY_VAL 32'h00000A5A
`define SCB_RST_STATUS 32'h10000000
`define SCB_RST_REGION_CACHE_POLICY 32'h00000000
`endif

// ==== rtl/scb_pkg.sv ====
// scb_pkg: types of the system control coprocessor
// assumes scb_params.svh on the include path
`include "scb_params.svh"
package scb_pkg;
  typedef enum logic [1:0] {SCB_FETCH, SCB_LOAD, SCB_STORE} scb_kind_t;
  typedef struct packed {
    logic [31:0] ibase, instr_space_limit, data_space_base, data_space_limit, badva, count, cmp, status;
    logic [31:0] exception_return_pc, config_r, region_cache_policy, fetch_breakpoint_addr, data_breakpoint_addr, ecc, cerr, tag, eepc;
    logic [4:0] code;
    logic tip, div, vsep, rvalid, rerr, rwatch;
    logic [31:0] rpaddr, prdata;
    logic [3:0] rattr;
  } scb_state_t;
endpackage

// ==== rtl/scb_cop.sv ====
// scb_cop: system control coprocessor with base/bound translation,
// cycle timer, watch exceptions and exception address capture.
// assumes pipeline inputs on pclk, apb master on pclk
//
// Contract
// - cycle counter advances every second clock
// - counter equal to match raises timer interrupt
// - reset and any exception enter kernel mode
// - kernel reaches both halves, user half only within bound, chooses fpu enable
// - user confined, coprocessor access can be blocked
// - user access checked against its bound
// - in bound: physical is base plus virtual
// - out of bound: address exception, no access
// - kernel segments use fixed translation
// - upper half reachable only in kernel
// - cached kernel window masks to physical
// - uncached window, upper segment unmapped
// - enabled watch match takes an exception
// - optional separate interrupt vector
// - address exception records faulting address
// - cache error saves pc separately
// - eight region cache attributes
`timescale 1ns/100ps
`include "scb_params.svh"
module scb_cop import scb_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pipeline access request
  input wire logic acc_valid,
  input wire scb_kind_t acc_kind,
  input wire logic [31:0] acc_vaddr,
  input wire logic [31:0] acc_pc,
  // translation answer
  output logic rsp_valid,
  output logic [31:0] rsp_paddr,
  output logic rsp_addr_err,
  output logic rsp_watch,
  output logic [3:0] rsp_attr,
  // other exceptions and return
  input wire logic exc_valid,
  input wire logic [4:0] exc_code,
  input wire logic exc_is_int,
  input wire logic exc_cache_err,
  input wire logic [31:0] exc_cache_info,
  input wire logic [31:0] exc_pc,
  input wire logic eret,
  // mode and timer
  output logic kernel_mode,
  output logic cop1_enable,
  output logic timer_irq,
  output logic int_vector_sep
);

  scb_state_t s_q, s_d;

  ////////////////////////////////////////////////////////////////////
  // helpers

  // kernel when not in user, or at exception or error level
  function automatic logic is_kernel(input logic [31:0] st);
    is_kernel = !st[`SCB_ST_UM] || st[`SCB_ST_EXL] || st[`SCB_ST_ERL];
  endfunction

  // register read mux, unused numbers give zero
  function automatic logic [31:0] rd_mux(input scb_state_t s, input logic [4:0] i);
    unique case (i)
      `SCB_IDX_IBASE: rd_mux = s.ibase;
      `SCB_IDX_INSTR_SPACE_LIMIT: rd_mux = s.instr_space_limit;
      `SCB_IDX_DATA_SPACE_BASE: rd_mux = s.data_space_base;
      `SCB_IDX_DATA_SPACE_LIMIT: rd_mux = s.data_space_limit;
      `SCB_IDX_BADVA: rd_mux = s.badva;
      `SCB_IDX_COUNT: rd_mux = s.count;
      `SCB_IDX_CMP: rd_mux = s.cmp;
      `SCB_IDX_STATUS: rd_mux = s.status;
      `SCB_IDX_CAUSE: rd_mux = {16'h0000, s.tip, 8'h00, s.code, 2'b00};
      `SCB_IDX_EPC: rd_mux = s.exception_return_pc;
      `SCB_IDX_PROCESSOR_IDENTITY: rd_mux = `SCB_PROCESSOR_IDENTITY_VAL;
      `SCB_IDX_CONFIG: rd_mux = s.config_r;
      `SCB_IDX_REGION_CACHE_POLICY: rd_mux = s.region_cache_policy;
      `SCB_IDX_FETCH_BREAKPOINT_ADDR: rd_mux = s.fetch_breakpoint_addr;
      `SCB_IDX_DATA_BREAKPOINT_ADDR: rd_mux = s.data_breakpoint_addr;
      `SCB_IDX_ECC: rd_mux = s.ecc;
      `SCB_IDX_CERR: rd_mux = s.cerr;
      `SCB_IDX_TAG: rd_mux = s.tag;
      `SCB_IDX_EEPC: rd_mux = s.eepc;
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // decode

  logic kern, mapped, blocked, wr_en, rd_en, tick, cnt_hit, in_bound, st_kind;
  logic [4:0] idx;
  logic [31:0] bound, base, cnt_inc, new_pa;
  logic [3:0] attr;

  // user software may be locked out of the coprocessor registers
  assign kern = is_kernel(s_q.status);
  assign blocked = !kern && !s_q.status[`SCB_ST_CU0];
  assign idx = paddr[6:2];
  assign mapped = (paddr[11:7] == 5'h00);
  assign wr_en = psel && penable && pwrite && mapped && !blocked;
  assign rd_en = psel && !penable && !pwrite && !blocked;
  assign tick = s_q.div;
  assign cnt_inc = s_q.count + 32'h00000001;
  assign cnt_hit = tick && (cnt_inc == s_q.cmp);
  assign st_kind = (acc_kind == SCB_STORE);
  // fetches use the instruction pair, loads and stores the data pair
  assign bound = (acc_kind == SCB_FETCH) ? s_q.instr_space_limit : s_q.data_space_limit;
  assign base = (acc_kind == SCB_FETCH) ? s_q.ibase : s_q.data_space_base;
  assign in_bound = (acc_vaddr <= bound);

  ////////////////////////////////////////////////////////////////////
  // segment translation and cache attribute

  always_comb begin
    new_pa = acc_vaddr;
    attr = s_q.region_cache_policy[{acc_vaddr[31:29], 2'b00} +: 4];
    if (acc_vaddr < `SCB_KSEG_BASE) begin
      new_pa = acc_vaddr + base;
    end else if (acc_vaddr < `SCB_UPPER_KERNEL_SEGMENT_BASE) begin
      new_pa = acc_vaddr & `SCB_WIN_MASK;
      if (acc_vaddr >= `SCB_UNCACHED_KERNEL_WINDOW_BASE) begin
        attr = `SCB_ATTR_UNCACHED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic err;
    logic wat;
    err = 1'b0;
    wat = 1'b0;
    s_d = s_q;
    s_d.div = !s_q.div;
    // counter tick, a software write below takes precedence
    if (tick) begin
      s_d.count = cnt_inc;
    end
    // unmapped addresses read zero too, never the last word caught
    s_d.prdata = rd_en ? (mapped ? rd_mux(s_q, idx) : 32'h00000000) : s_q.prdata;
    // register writes, read-only and unused numbers drop the data
    if (wr_en) begin
      unique case (idx)
        `SCB_IDX_IBASE: s_d.ibase = pwdata;
        `SCB_IDX_INSTR_SPACE_LIMIT: s_d.instr_space_limit = pwdata;
        `SCB_IDX_DATA_SPACE_BASE: s_d.data_space_base = pwdata;
        `SCB_IDX_DATA_SPACE_LIMIT: s_d.data_space_limit = pwdata;
        `SCB_IDX_COUNT: s_d.count = pwdata;
        `SCB_IDX_CMP: begin
          s_d.cmp = pwdata;
          s_d.tip = 1'b0; // writing the match value acknowledges the timer
        end
        `SCB_IDX_STATUS: s_d.status = pwdata;
        `SCB_IDX_CAUSE: s_d.code = pwdata[6:2];
        `SCB_IDX_EPC: s_d.exception_return_pc = pwdata;
        `SCB_IDX_CONFIG: s_d.config_r = pwdata;
        `SCB_IDX_REGION_CACHE_POLICY: s_d.region_cache_policy = pwdata;
        `SCB_IDX_FETCH_BREAKPOINT_ADDR: s_d.fetch_breakpoint_addr = pwdata;
        `SCB_IDX_DATA_BREAKPOINT_ADDR: s_d.data_breakpoint_addr = pwdata;
        `SCB_IDX_ECC: s_d.ecc = pwdata;
        `SCB_IDX_TAG: s_d.tag = pwdata;
        `SCB_IDX_EEPC: s_d.eepc = pwdata;
        default: ;
      endcase
    end
    // a match in the same cycle as the acknowledge still sets
    if (cnt_hit) begin
      s_d.tip = 1'b1;
    end
    // return leaves the error level first, then the exception level
    if (eret) begin
      if (s_q.status[`SCB_ST_ERL]) begin
        s_d.status[`SCB_ST_ERL] = 1'b0;
      end else begin
        s_d.status[`SCB_ST_EXL] = 1'b0;
      end
    end
    // address check: upper half needs kernel, user half needs bound
    if (acc_valid) begin
      if (acc_vaddr >= `SCB_KSEG_BASE) begin
        err = !kern;
      end else begin
        err = !in_bound;
      end
      if (acc_kind == SCB_FETCH) begin
        wat = s_q.fetch_breakpoint_addr[`SCB_WI_EN] && (acc_vaddr[31:2] == s_q.fetch_breakpoint_addr[31:2]);
      end else begin
        wat = (st_kind ? s_q.data_breakpoint_addr[`SCB_WD_ST] : s_q.data_breakpoint_addr[`SCB_WD_LD])
          && (acc_vaddr[31:3] == s_q.data_breakpoint_addr[31:3]);
      end
    end
    s_d.rvalid = acc_valid;
    s_d.rerr = err;
    s_d.rwatch = wat && !err;
    s_d.rpaddr = err ? 32'h00000000 : new_pa;
    s_d.rattr = attr;
    // exceptions win over a return or a software write of status
    if (err || wat) begin
      s_d.badva = err ? acc_vaddr : s_q.badva;
      s_d.exception_return_pc = acc_pc;
      s_d.code = err ? (st_kind ? `SCB_CODE_ADES : `SCB_CODE_ADEL) : `SCB_CODE_WATCH;
      s_d.status[`SCB_ST_EXL] = 1'b1;
      s_d.vsep = 1'b0;
    end else if (exc_valid) begin
      if (exc_cache_err) begin
        s_d.eepc = exc_pc;
        s_d.cerr = exc_cache_info;
        s_d.status[`SCB_ST_ERL] = 1'b1;
      end else begin
        s_d.exception_return_pc = exc_pc;
        s_d.code = exc_code;
        s_d.status[`SCB_ST_EXL] = 1'b1;
      end
      s_d.vsep = exc_is_int && s_q.status[`SCB_ST_IVEC];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register, comes up in kernel mode with user bit clear

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.status <= `SCB_RST_STATUS;
      s_q.region_cache_policy <= `SCB_RST_REGION_CACHE_POLICY;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states: the read word was caught during the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && blocked;
  assign prdata = s_q.prdata;
  assign rsp_valid = s_q.rvalid;
  assign rsp_paddr = s_q.rpaddr;
  assign rsp_addr_err = s_q.rerr;
  assign rsp_watch = s_q.rwatch;
  assign rsp_attr = s_q.rattr;
  assign kernel_mode = kern;
  // kernel decides, user only gets it if kernel granted it
  assign cop1_enable = s_q.status[`SCB_ST_CU1];
  assign timer_irq = s_q.tip;
  assign int_vector_sep = s_q.vsep;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_count_rate;
    !(wr_en && idx == `SCB_IDX_COUNT) ##1 !(wr_en && idx == `SCB_IDX_COUNT)
      |=> s_q.count == $past(s_q.count, 2) + 32'h00000001;
  endproperty
  a_count_rate: assert property (p_count_rate) else $error("count rate wrong");

  property p_timer;
    cnt_hit |=> timer_irq;
  endproperty
  a_timer: assert property (p_timer) else $error("timer not raised");

  property p_exc_kernel;
    (exc_valid || (acc_valid && !kern && acc_vaddr[31])) |=> kernel_mode;
  endproperty
  a_exc_kernel: assert property (p_exc_kernel) else $error("no kernel on exception");

  property p_oob;
    acc_valid && !acc_vaddr[31] && acc_vaddr > bound |=> rsp_valid && rsp_addr_err;
  endproperty
  a_oob: assert property (p_oob) else $error("out of bound not caught");

  property p_reloc;
    acc_valid && !acc_vaddr[31] && acc_vaddr <= bound
      |=> !rsp_addr_err && rsp_paddr == $past(acc_vaddr) + $past(base);
  endproperty
  a_reloc: assert property (p_reloc) else $error("relocation wrong");

  property p_user_high;
    acc_valid && !kern && acc_vaddr[31] |=> rsp_addr_err;
  endproperty
  a_user_high: assert property (p_user_high) else $error("user reached kernel");

  property p_window;
    acc_valid && kern && acc_vaddr[31:30] == 2'b10
      |=> rsp_paddr == ($past(acc_vaddr) & `SCB_WIN_MASK);
  endproperty
  a_window: assert property (p_window) else $error("kernel window wrong");

  property p_badva;
    acc_valid && !acc_vaddr[31] && acc_vaddr > bound |=> s_q.badva == $past(acc_vaddr);
  endproperty
  a_badva: assert property (p_badva) else $error("fault address lost");

  property p_cerr_pc;
    exc_valid && exc_cache_err && !(acc_valid && (acc_vaddr > bound || acc_vaddr[31]))
      |=> s_q.eepc == $past(exc_pc) && s_q.exception_return_pc == $past(s_q.exception_return_pc);
  endproperty
  a_cerr_pc: assert property (p_cerr_pc) else $error("error pc wrong");

  property p_unused;
    psel && !penable && !pwrite && !blocked && idx == 5'h04 |=> prdata == 32'h00000000;
  endproperty
  a_unused: assert property (p_unused) else $error("unused reads nonzero");

  property p_fetch_watch;
    acc_valid && acc_kind == SCB_FETCH && !acc_vaddr[31] && acc_vaddr <= bound
      && s_q.fetch_breakpoint_addr[`SCB_WI_EN] && acc_vaddr[31:2] == s_q.fetch_breakpoint_addr[31:2] |=> rsp_watch;
  endproperty
  a_fetch_watch: assert property (p_fetch_watch) else $error("fetch watch missed");

  property p_uncached;
    acc_valid && acc_vaddr >= `SCB_UNCACHED_KERNEL_WINDOW_BASE && acc_vaddr < `SCB_UPPER_KERNEL_SEGMENT_BASE
      |=> rsp_attr == `SCB_ATTR_UNCACHED;
  endproperty
  a_uncached: assert property (p_uncached) else $error("uncached attr wrong");

  property p_int_vector;
    exc_valid && exc_is_int && !exc_cache_err && s_q.status[`SCB_ST_IVEC] && !acc_valid
      |=> int_vector_sep;
  endproperty
  a_int_vector: assert property (p_int_vector) else $error("int vector not split");

endmodule

// ==== test/scb_pipe_model.sv ====
// scb_pipe_model: pipeline side that issues fetch, load and store requests
// assumes the coprocessor answers one clock after it takes a request
`timescale 1ns/100ps
module scb_pipe_model import scb_pkg::*; (
  // clock
  input wire logic pclk,
  // request toward the coprocessor
  output logic acc_valid,
  output scb_kind_t acc_kind,
  output logic [31:0] acc_vaddr,
  output logic [31:0] acc_pc,
  // translation answer
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_paddr,
  input wire logic rsp_addr_err,
  input wire logic rsp_watch,
  input wire logic [3:0] rsp_attr
);
  logic [31:0] rsp_pa;
  logic [6:0] rsp_fl;
  ////////////////////////////////////////////////////////////////////////
  // idle request lines from time zero
  initial begin
    acc_valid = 1'h0;
    acc_kind = SCB_FETCH;
    acc_vaddr = 32'h0;
    acc_pc = 32'h0;
  end
  // one-cycle request; once taken the address shows its inverse, so a
  // design that keeps using a stale address gets the wrong answer
  task automatic issue(input scb_kind_t k, input logic [31:0] va);
    @(posedge pclk);
    acc_valid <= 1'h1;
    acc_kind <= k;
    acc_vaddr <= va;
    acc_pc <= va ^ 32'h00000F00;
    @(posedge pclk);
    acc_valid <= 1'h0;
    acc_vaddr <= ~va;
    @(posedge pclk);
    rsp_pa = rsp_paddr;
    rsp_fl = {rsp_valid, rsp_addr_err, rsp_watch, rsp_attr};
    #1;
  endtask
endmodule

// ==== test/tb_scb_cop.sv ====
// tb_scb_cop: self-checking bench for the system control coprocessor
// assumes zero-wait apb answers and the pipeline model beside the design
`timescale 1ns/100ps
module tb_scb_cop import scb_pkg::*; ;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic exc_valid = 1'h0, exc_is_int = 1'h0, exc_cache_err = 1'h0, eret = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [4:0] exc_code = 5'h08;
  logic [31:0] pwdata = 32'h0, exc_pc = 32'h0, prdata, rq, c, va, pa, acc_vaddr, acc_pc, rsp_paddr;
  logic pready, pslverr, serr, acc_valid, rsp_valid, rsp_addr_err, rsp_watch;
  logic kernel_mode, cop1_enable, timer_irq, int_vector_sep;
  logic [3:0] rsp_attr, at;
  scb_kind_t acc_kind;
  int err_count = 0;
  int n_tests = 0;
  int n;
  logic [31:0] va_t [6] = '{32'h00000FFF, 32'h00000FFF, 32'h60000010, 32'h80001234,
    32'hA0001234, 32'hC0001234};
  scb_kind_t kd_t [6] = '{SCB_FETCH, SCB_LOAD, SCB_STORE, SCB_LOAD, SCB_FETCH, SCB_STORE};
  ////////////////////////////////////////////////////////////////////////
  scb_cop scb_cop_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_vaddr(acc_vaddr),
    .acc_pc(acc_pc), .rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr),
    .rsp_addr_err(rsp_addr_err), .rsp_watch(rsp_watch), .rsp_attr(rsp_attr),
    .exc_valid(exc_valid), .exc_code(exc_code), .exc_is_int(exc_is_int),
    .exc_cache_err(exc_cache_err), .exc_cache_info(~exc_pc), .exc_pc(exc_pc), .eret(eret),
    .kernel_mode(kernel_mode), .cop1_enable(cop1_enable), .timer_irq(timer_irq),
    .int_vector_sep(int_vector_sep));
  scb_pipe_model scb_pipe_model_inst (.pclk(pclk), .acc_valid(acc_valid),
    .acc_kind(acc_kind), .acc_vaddr(acc_vaddr), .acc_pc(acc_pc), .rsp_valid(rsp_valid),
    .rsp_paddr(rsp_paddr), .rsp_addr_err(rsp_addr_err), .rsp_watch(rsp_watch),
    .rsp_attr(rsp_attr));
  ////////////////////////////////////////////////////////////////////////
  // clock and a watchdog that ends a hung run as a mismatch
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    chk("run time", 32'h0, 32'h1);
    results();
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 20 && pready !== 1'h1; i++) @(posedge pclk);
    chk("pready", 32'h1, 32'(pready));
    rq = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk($sformatf("register %h", a), e, rq);
  endtask
  // m: bit2 return, bit1 cache error, bit0 interrupt
  task automatic pulse(input logic [2:0] m, input logic [31:0] pc);
    @(posedge pclk);
    exc_valid <= ~m[2];
    eret <= m[2];
    exc_cache_err <= m[1];
    exc_is_int <= m[0];
    exc_pc <= pc;
    @(posedge pclk);
    exc_valid <= 1'h0;
    eret <= 1'h0;
    #1;
  endtask
  task automatic km(input logic e);
    chk("kernel mode", 32'(e), 32'(kernel_mode));
  endtask
  task automatic acc(input scb_kind_t k, input logic [31:0] v, input logic [31:0] p,
      input logic [3:0] t, input logic [1:0] ew);
    scb_pipe_model_inst.issue(k, v);
    chk("paddr", p, scb_pipe_model_inst.rsp_pa);
    chk("answer", 32'({1'h1, ew, t}), 32'(scb_pipe_model_inst.rsp_fl));
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    km(1'h1);
    presetn <= 1'h1;
    rd(12'h030, 32'h10000000);
    rd(12'h03C, 32'h00000A5A);
    rd(12'h800, 32'h0);
    wr(12'h010, 32'hFFFFFFFF);
    rd(12'h010, 32'h0);
    $display("test reset done");
    wr(12'h000, 32'h00100000);
    wr(12'h004, 32'h00000FFF);
    wr(12'h008, 32'h00200000);
    wr(12'h00C, 32'h7FFFFFFF);
    wr(12'h044, 32'h76543210);
    for (int i = 0; i < 6; i++) begin
      va = va_t[i];
      pa = va + ((kd_t[i] == SCB_FETCH) ? 32'h00100000 : 32'h00200000);
      if (va[31]) pa = va[30] ? va : (va & 32'h1FFFFFFF);
      at = (va[31:29] == 3'h5) ? 4'h2 : {1'h0, va[31:29]};
      acc(kd_t[i], va, pa, at, 2'h0);
    end
    acc(SCB_FETCH, 32'h00001000, 32'h0, 4'h0, 2'h2);
    km(1'h1);
    wr(12'h020, 32'h0);
    rd(12'h020, 32'h00001000);
    $display("test translation done");
    pulse(3'h4, 32'h0);
    wr(12'h030, 32'h10000010);
    km(1'h0);
    scb_pipe_model_inst.issue(SCB_LOAD, 32'h80000000);
    chk("user fault", 32'h1, 32'(scb_pipe_model_inst.rsp_fl[5]));
    km(1'h1);
    rd(12'h020, 32'h80000000);
    rd(12'h034, 32'h00000010);
    pulse(3'h4, 32'h0);
    wr(12'h030, 32'h00000010);
    wr(12'h044, 32'h0);
    chk("refused", 32'h1, 32'(serr));
    pulse(3'h1, 32'h00000400);
    km(1'h1);
    chk("vector", 32'h0, 32'(int_vector_sep));
    rd(12'h044, 32'h76543210);
    wr(12'h030, 32'h30800000);
    chk("fpu enable", 32'h1, 32'(cop1_enable));
    pulse(3'h1, 32'h00000400);
    chk("vector", 32'h1, 32'(int_vector_sep));
    pulse(3'h2, 32'h12345678);
    rd(12'h078, 32'h12345678);
    rd(12'h06C, 32'hEDCBA987);
    rd(12'h038, 32'h00000400);
    $display("test modes done");
    wr(12'h048, 32'h00000101);
    wr(12'h04C, 32'h00000202);
    acc(SCB_FETCH, 32'h00000100, 32'h00100100, 4'h0, 2'h1);
    acc(SCB_LOAD, 32'h00000200, 32'h00200200, 4'h0, 2'h1);
    acc(SCB_STORE, 32'h00000200, 32'h00200200, 4'h0, 2'h0);
    $display("test watch done");
    apb(1'h0, 12'h024, 32'h0);
    c = rq;
    apb(1'h0, 12'h024, 32'h0);
    chk("count half step", 32'h1, 32'(rq - c == 32'h1 || rq - c == 32'h2));
    apb(1'h0, 12'h024, 32'h0);
    chk("count step", c + 32'h3, rq);
    wr(12'h024, 32'h0);
    wr(12'h02C, 32'h00000006);
    chk("timer idle", 32'h0, 32'(timer_irq));
    n = 0;
    while (timer_irq !== 1'h1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    chk("timer delay", 32'h1, 32'(n >= 9 && n <= 12));
    wr(12'h02C, 32'h00000100);
    chk("timer cleared", 32'h0, 32'(timer_irq));
    $display("test timer done");
    results();
  end
endmodule
